/* File: hw/status_word_map.vh */
/*
 status word map: register offset, field positions, reset value and bus timing.
 assumes inclusion by hw/program_status_flags.v only; definitions only.
*/
`ifndef STATUS_WORD_MAP_VH
`define STATUS_WORD_MAP_VH

// byte address of the status word on the avalon bus
`define STATUS_WORD_ADDR  8'hd0
// byte address of a read-only view of core state (accumulator, bank base)
`define CORE_VIEW_ADDR    8'hd4
`define STATUS_WORD_RESET 8'h00
`define CARRY_BIT         7
`define AUX_CARRY_BIT     6
`define USER_A_BIT        5
`define BANK_HI_BIT       4
`define BANK_LO_BIT       3
`define OVERFLOW_BIT      2
`define USER_B_BIT        1
`define PARITY_BIT        0
// cycles of waitrequest before a read is answered
`define READ_WAIT_CYCLES  1
`define BANK_SIZE         8

`endif

/* File: hw/program_status_flags.v */
/*
 program status word of a small microcontroller core: arithmetic flags,
 boolean accumulator, two user flags and working register bank select.
 assumes the alu and execution logic run on ref_clk and present update
 strobes for one cycle; software reaches the word over avalon-mm.
*/
// Local design decision: the Avalon-MM register port.
// Functional notes
// - the carry flag in bit 7 is set when an arithmetic operation carries out of the alu.
// - the carry flag serves as the one-bit accumulator for boolean bit operations.
// - the auxiliary carry flag in bit 6 records the carry out of the lower nibble.
// - bit 5 is a user flag that only software changes.
// - bank select bits 4 and 3 pick working register base 00h, 08h, 10h or 18h.
// - the overflow flag in bit 2 is the exclusive or of carries out of bits 6 and 7.
// - bit 1 is a second user flag that only software changes.
// - the parity flag in bit 0 is set for an odd number of ones in the accumulator.
`timescale 1ns/1ps
`include "status_word_map.vh"

module program_status_flags #(
    parameter WORD_WIDTH = 8
) (
    input  wire                  ref_clk,
    input  wire                  srst,
    // avalon-mm slave
    input  wire [7:0]            address,
    input  wire                  read,
    input  wire                  write,
    input  wire [31:0]           writedata,
    input  wire [3:0]            byteenable,
    output reg  [31:0]           readdata,
    output wire                  waitrequest,
    output reg  [1:0]            response,
    // alu side
    input  wire [WORD_WIDTH-1:0] acc,
    input  wire                  arith_upd,
    input  wire [WORD_WIDTH-1:0] alu_a,
    input  wire [WORD_WIDTH-1:0] alu_b,
    input  wire                  alu_cin,
    input  wire                  alu_sub,
    input  wire                  bool_upd,
    input  wire [1:0]            bool_op,
    input  wire                  bool_bit,
    input  wire                  carry_load,
    input  wire                  carry_value,
    // state shown to the core
    output wire [7:0]            program_status_word,
    output wire                  carry_flag,
    output wire [4:0]            bank_base
);

    localparam BOOL_MOV  = 2'h0;
    localparam BOOL_AND  = 2'h1;
    localparam BOOL_OR   = 2'h2;
    localparam BOOL_CPL  = 2'h3;
    localparam ST_IDLE   = 1'b0;
    localparam ST_ANSWER = 1'b1;

    reg                  carry_r;
    reg                  aux_carry_r;
    reg                  user_a_r;
    reg [1:0]            bank_r;
    reg                  overflow_r;
    reg                  user_b_r;
    reg                  state_r;
    reg [WORD_WIDTH:0]   sum;
    reg [4:0]            low_sum;
    reg [WORD_WIDTH-1:0] low_part;
    reg                  carry_into_msb;
    reg                  bool_result;
    wire                 parity;
    wire                 psw_hit;
    wire                 view_hit;
    wire                 sw_write;

    // true when the address selects a mapped register
    function hit;
        input [7:0] addr;
        input [7:0] target;
        begin
            hit = (addr == target);
        end
    endfunction

    assign psw_hit  = hit(address, `STATUS_WORD_ADDR);
    assign view_hit = hit(address, `CORE_VIEW_ADDR);
    // writes complete at once; reads take one wait cycle to register data
    assign waitrequest = read & (state_r == ST_IDLE);
    assign sw_write    = write & psw_hit & byteenable[0];

    assign parity = ^acc;

    // alu carries: subtraction adds the inverted operand with inverted borrow
    always @* begin
        low_part       = alu_sub ? ~alu_b : alu_b;
        sum            = {1'b0, alu_a} + {1'b0, low_part} + {{WORD_WIDTH{1'b0}}, alu_cin ^ alu_sub};
        low_sum        = {1'b0, alu_a[3:0]} + {1'b0, low_part[3:0]}
                       + {4'h0, alu_cin ^ alu_sub};
        carry_into_msb = alu_a[WORD_WIDTH-1] ^ low_part[WORD_WIDTH-1] ^ sum[WORD_WIDTH-1];
    end

    always @* begin
        case (bool_op)
            BOOL_MOV: bool_result = bool_bit;
            BOOL_AND: bool_result = carry_r & bool_bit;
            BOOL_OR:  bool_result = carry_r | bool_bit;
            BOOL_CPL: bool_result = ~carry_r;
            default:  bool_result = carry_r;
        endcase
    end

    // hardware updates take priority over a software write in the same cycle,
    // so no alu result is lost
    always @(posedge ref_clk) begin
        if (srst) begin
            carry_r     <= 1'b0;
            aux_carry_r <= 1'b0;
            user_a_r    <= 1'b0;
            bank_r      <= 2'b00;
            overflow_r  <= 1'b0;
            user_b_r    <= 1'b0;
        end else begin
            if (sw_write) begin
                carry_r     <= writedata[`CARRY_BIT];
                aux_carry_r <= writedata[`AUX_CARRY_BIT];
                user_a_r    <= writedata[`USER_A_BIT];
                bank_r      <= {writedata[`BANK_HI_BIT], writedata[`BANK_LO_BIT]};
                overflow_r  <= writedata[`OVERFLOW_BIT];
                user_b_r    <= writedata[`USER_B_BIT];
            end
            if (arith_upd) begin
                carry_r     <= sum[WORD_WIDTH] ^ alu_sub;
                aux_carry_r <= low_sum[4] ^ alu_sub;
                overflow_r  <= sum[WORD_WIDTH] ^ carry_into_msb;
            end else if (bool_upd) begin
                carry_r <= bool_result;
            end else if (carry_load) begin
                carry_r <= carry_value;
            end
        end
    end

    assign program_status_word = {carry_r, aux_carry_r, user_a_r, bank_r,
                                  overflow_r, user_b_r, parity};
    assign carry_flag = carry_r;
    assign bank_base  = {bank_r, 3'b000};

    // read path: one wait cycle, then data and response stand with waitrequest low
    always @(posedge ref_clk) begin
        if (srst) begin
            state_r  <= ST_IDLE;
            readdata <= 32'h0000_0000;
            response <= 2'b00;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (read) begin
                        state_r <= ST_ANSWER;
                        if (psw_hit) begin
                            readdata <= {24'h00_0000, program_status_word};
                            response <= 2'b00;
                        end else if (view_hit) begin
                            readdata <= {19'h0_0000, bank_base, acc};
                            response <= 2'b00;
                        end else begin
                            readdata <= 32'h0000_0000;
                            response <= 2'b10;
                        end
                    end else if (write) begin
                        response <= (psw_hit | view_hit) ? 2'b00 : 2'b10;
                    end
                end
                ST_ANSWER: begin
                    state_r <= ST_IDLE;
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

endmodule // program_status_flags

/* File: tb/psf_chk.sv */
/* flag checker; sees design ports only, bound at the foot */
`timescale 1ns/1ps
module psf_chk (
    input wire       ref_clk, srst, write, arith_upd, alu_cin, alu_sub, bool_upd,
    input wire       bool_bit, carry_load, carry_value, carry_flag,
    input wire [7:0] address, acc, alu_a, alu_b, program_status_word,
    input wire [1:0] bool_op,
    input wire [4:0] bank_base
);
    wire [7:0] p = program_status_word;
    wire [8:0] s = alu_a + alu_b + alu_cin;
    wire [4:0] n = alu_a[3:0] + alu_b[3:0] + alu_cin;
    wire [7:0] l = alu_a[6:0] + alu_b[6:0] + alu_cin;
    wire       ov = l[7] ^ s[8];
    wire       ad = arith_upd & ~alu_sub;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);
    parity_a: assert property (p[0] == ^acc) else $error("parity");
    bank_base_a: assert property (bank_base == {p[4:3], 3'h0}) else $error("bank");
    carry_out_a: assert property (ad |=> p[7] == $past(s[8])) else $error("carry");
    aux_carry_a: assert property (ad |=> p[6] == $past(n[4])) else $error("aux");
    overflow_a: assert property (ad |=> p[2] == $past(ov)) else $error("ovf");
    carry_load_a: assert property (carry_load & ~arith_upd & ~bool_upd |=>
        carry_flag == $past(carry_value)) else $error("load");
    bool_and_a: assert property (bool_upd & bool_op == 2'h1 & ~arith_upd |=>
        carry_flag == ($past(carry_flag) & $past(bool_bit))) else $error("and");
    sw_only_a: assert property (!(write && address == 8'hd0) |=>
        $stable({p[5:3], p[1]})) else $error("user");
endmodule // psf_chk
bind program_status_flags psf_chk i_psf_chk (.*);

/* File: tb/alu_model.sv */
/* alu partner; tasks are called from the bench */
`timescale 1ns/1ps
module alu_model (
    input  wire       ref_clk,
    output reg  [7:0] acc = 8'h00, alu_a = 8'h00, alu_b = 8'h00,
    output reg        arith_upd = 1'b0, alu_cin = 1'b0, alu_sub = 1'b0,
    output reg        bool_upd = 1'b0, bool_bit = 1'b0, carry_load = 1'b0, carry_value = 1'b0,
    output reg  [1:0] bool_op = 2'h0
);
    // each strobe starts on a fresh edge, so two updates never merge
    task arith(input [7:0] a, b, input c, s);
        @(posedge ref_clk);
        {alu_a, alu_b, alu_cin, alu_sub, arith_upd} <= {a, b, c, s, 1'b1};
        @(posedge ref_clk) arith_upd <= 1'b0;
    endtask
    task bool(input [1:0] op, input bt);
        @(posedge ref_clk);
        {bool_op, bool_bit, bool_upd} <= {op, bt, 1'b1};
        @(posedge ref_clk) bool_upd <= 1'b0;
    endtask
    task load(input v);
        @(posedge ref_clk);
        {carry_value, carry_load} <= {v, 1'b1};
        @(posedge ref_clk) carry_load <= 1'b0;
    endtask
    task set_acc(input [7:0] v);
        @(posedge ref_clk) acc <= v;
        @(posedge ref_clk);
    endtask
endmodule // alu_model

/* File: tb/program_status_flags_test.sv */
/* bench for program_status_flags; avalon master plus alu partner */
`timescale 1ns/1ps
module program_status_flags_test;
    reg         ref_clk = 1'b0, srst = 1'b1, read = 1'b0, write = 1'b0;
    reg  [7:0]  address = 8'h00;
    reg  [31:0] writedata = 32'h0, d;
    reg  [3:0]  byteenable = 4'h1;
    reg  [1:0]  r;
    wire [31:0] readdata;
    wire [7:0]  acc, alu_a, alu_b, program_status_word;
    wire [4:0]  bank_base;
    wire [1:0]  response, bool_op;
    wire        waitrequest, arith_upd, alu_cin, alu_sub, bool_upd, bool_bit;
    wire        carry_load, carry_value, carry_flag;
    int         error_cnt = 0, n_compared = 0;
    always #5 ref_clk = ~ref_clk;
    alu_model i_alu_model (.*);
    program_status_flags i_program_status_flags (.*);
    task end_of_test;
        $display("compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task chk(input string nm, input [31:0] e, g);
        n_compared++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", nm, e, g);
        end
    endtask
    task bus(input w, input [7:0] a, wd);
        int n;
        n = 0;
        @(posedge ref_clk);
        {address, write, read, writedata} <= {a, w, !w, 24'h0, wd};
        do begin
            @(posedge ref_clk);
            if (++n > 40) begin error_cnt++; end_of_test; end
        end while (waitrequest !== 1'b0);
        {d, r} = {readdata, response};
        {read, write} <= 2'h0;
    endtask
    task ar(input [7:0] a, b, e);
        i_alu_model.arith(a, b, 1'b0, 1'b0);
        @(negedge ref_clk) chk("flags", e, program_status_word);
    endtask
    initial begin
        repeat (16) @(posedge ref_clk);
        srst <= 1'b0;
        bus(0, 8'hd0, 8'h0);
        chk("reset read", 32'h0, d);
        bus(0, 8'hc0, 8'h0);
        chk("unmapped", 32'h2, {d, r});
        ar(8'hff, 8'h01, 8'hc0);
        ar(8'h7f, 8'h01, 8'h44);
        ar(8'h80, 8'h80, 8'h84);
        i_alu_model.load(1'b1);
        @(negedge ref_clk) chk("load", 1, carry_flag);
        for (int i = 0; i < 4; i++) begin
            i_alu_model.bool(i[1:0], i == 1 || i == 2);
            @(negedge ref_clk) chk("bool", i == 2, carry_flag);
        end
        for (int b = 0; b < 4; b++) begin
            bus(1, 8'hd0, 8'h23 | b << 3);
            @(negedge ref_clk) chk("base", b * 8, bank_base);
            chk("psw", 8'h22 | b << 3, program_status_word);
        end
        ar(8'hff, 8'h01, 8'hfa);
        byteenable <= 4'h0;
        bus(1, 8'hd0, 8'h00);
        byteenable <= 4'h1;
        i_alu_model.set_acc(8'h07);
        bus(0, 8'hd0, 8'h0);
        chk("psw read", 32'hfb, d);
        bus(0, 8'hd4, 8'h0);
        chk("core view", 32'h1807, d);
        i_alu_model.arith(8'h80, 8'h01, 1'b0, 1'b1);
        @(negedge ref_clk) chk("sub flags", 8'h7f, program_status_word);
        end_of_test;
    end
endmodule // program_status_flags_test
